// ===== rtl/tcs_pkg.sv
`default_nettype none
package tcs_pkg;

  // ******************************************************
  // Geometry
  // ******************************************************
  localparam int CH_NUM = 4;
  localparam int CNT_W  = 24;
  localparam int PRE_W  = 8;
  localparam int ADDR_W = 10;

  // ******************************************************
  // Byte offsets and register word indexes on the register bus
  // ******************************************************
  localparam logic [9:0] TIMER_PAIR_A_BASE = 10'h000;
  localparam logic [9:0] TIMER_PAIR_B_BASE = 10'h100;
  localparam logic [9:0] CH_FIRST_OFS      = 10'h000;
  localparam logic [9:0] CH_SECOND_OFS     = 10'h020;
  localparam logic [1:0] CTRL_IDX          = 2'h0;
  localparam logic [1:0] CMP_IDX           = 2'h1;
  localparam logic [1:0] DATA_IDX          = 2'h3;
  localparam logic [9:0] IRQ_STATUS_OFS    = 10'h200;
  localparam logic [9:0] IRQ_MASK_OFS      = 10'h204;

  // ******************************************************
  // Control and status field positions
  // ******************************************************
  localparam int COUNT_ENABLE_BIT   = 30;
  localparam int IRQ_ENABLE_BIT     = 29;
  localparam int MODE_HI_BIT        = 28;
  localparam int MODE_LO_BIT        = 27;
  localparam int CLEAR_BIT          = 26;
  localparam int ACTIVE_BIT         = 25;
  localparam int EVENT_SEL_BIT      = 24;
  localparam int SNAPSHOT_BIT       = 16;
  localparam int DIVIDE_HI_BIT      = 7;

  // ******************************************************
  // Reset values and mode codes
  // ******************************************************
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0005;
  localparam logic [1:0]  MODE_ONE_SHOT = 2'h0;
  localparam logic [1:0]  MODE_PERIODIC = 2'h1;
  localparam logic [1:0]  MODE_TOGGLE   = 2'h2;
  localparam logic [1:0]  MODE_AUTO     = 2'h3;

endpackage : tcs_pkg
`default_nettype wire

// ===== rtl/tcs_timer_control_status.sv
// Chosen here: the Avalon-MM register port.
`default_nettype none
module tcs_timer_control_status (
  // Clock, reset, freeze
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  // Avalon-MM slave
  input  wire logic [tcs_pkg::ADDR_W-1:0] address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  // Channel outputs
  output logic      [tcs_pkg::CH_NUM-1:0] toggle_out,
  output logic                            irq
);

  // ******************************************************
  // Bus decode
  // ******************************************************
  logic [tcs_pkg::CH_NUM-1:0] count_enable;
  logic [tcs_pkg::CH_NUM-1:0] match_irq_enable;
  logic [1:0]                 mode [tcs_pkg::CH_NUM];
  logic [tcs_pkg::CH_NUM-1:0] event_count_select;
  logic [tcs_pkg::CH_NUM-1:0] data_snapshot_enable;
  logic [7:0]                 clock_divide_value [tcs_pkg::CH_NUM];
  logic [23:0]                compare_value_register [tcs_pkg::CH_NUM];
  logic [23:0]                live_count_register [tcs_pkg::CH_NUM];
  logic [23:0]                count_reg [tcs_pkg::CH_NUM];
  logic [tcs_pkg::CH_NUM-1:0] irq_status_reg;
  logic [tcs_pkg::CH_NUM-1:0] irq_mask_reg;
  logic [tcs_pkg::CH_NUM-1:0] match_event;
  logic                       wr_go;
  logic [31:0]                rd_next;

  // Channel register hit: pair by bit 8, channel by bit 5
  function automatic logic ch_hit(
    input logic [tcs_pkg::ADDR_W-1:0] a,
    input int                         ch,
    input logic [1:0]                 idx
  );
    logic [9:0] base;
    base = ch[1] ? tcs_pkg::TIMER_PAIR_B_BASE
                 : tcs_pkg::TIMER_PAIR_A_BASE;
    base = base | (ch[0] ? tcs_pkg::CH_SECOND_OFS
                         : tcs_pkg::CH_FIRST_OFS);
    return a == (base | {6'h00, idx, 2'h0});
  endfunction : ch_hit

  // Byte lanes expanded to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // A write takes effect at the edge where waitrequest is seen low
  assign wr_go = write && !waitrequest;

  // ******************************************************
  // Per-channel timers
  // ******************************************************
  genvar gi;
  generate
    for (gi = 0; gi < tcs_pkg::CH_NUM; gi++) begin : g_ch
      logic        wr_ctrl;
      logic        wr_cmp;
      logic        clear_go;
      logic        tick;
      logic        match;
      logic [7:0]  clock_divide_value_reg;
      logic [23:0] count_inc;
      logic [31:0] wmask;

      assign wmask     = lane_mask(byteenable);
      assign wr_ctrl   = wr_go && ch_hit(address, gi, tcs_pkg::CTRL_IDX);
      assign wr_cmp    = wr_go && ch_hit(address, gi, tcs_pkg::CMP_IDX);
      // Clear is a pulse, never stored, so it always reads zero
      assign clear_go  = wr_ctrl && byteenable[3] &&
                         writedata[tcs_pkg::CLEAR_BIT];
      assign tick      = count_enable[gi] &&
                         (clock_divide_value_reg == clock_divide_value[gi]);
      assign count_inc = count_reg[gi] + 24'h00_0001;
      assign match     = tick &&
                         (count_inc == compare_value_register[gi]);
      assign match_event[gi] = match && match_irq_enable[gi];

      // Control fields; bus write wins over the hardware stop
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          count_enable[gi]         <= tcs_pkg::CTRL_RESET[30];
          match_irq_enable[gi]     <= tcs_pkg::CTRL_RESET[29];
          mode[gi]                 <= tcs_pkg::CTRL_RESET[28:27];
          event_count_select[gi]   <= tcs_pkg::CTRL_RESET[24];
          data_snapshot_enable[gi] <= tcs_pkg::CTRL_RESET[16];
          clock_divide_value[gi]   <= tcs_pkg::CTRL_RESET[7:0];
        end else if (ce) begin
          if (wr_ctrl && byteenable[3]) begin
            count_enable[gi] <= writedata[tcs_pkg::COUNT_ENABLE_BIT] &&
                                !clear_go;
            match_irq_enable[gi] <= writedata[tcs_pkg::IRQ_ENABLE_BIT];
            mode[gi] <= writedata[tcs_pkg::MODE_HI_BIT:
                                  tcs_pkg::MODE_LO_BIT];
            event_count_select[gi] <= writedata[tcs_pkg::EVENT_SEL_BIT];
          end else if (match && mode[gi] == tcs_pkg::MODE_ONE_SHOT) begin
            count_enable[gi] <= 1'b0;
          end
          // Active and reserved bits have no storage
          if (wr_ctrl && byteenable[2]) begin
            data_snapshot_enable[gi] <= writedata[tcs_pkg::SNAPSHOT_BIT];
          end
          if (wr_ctrl && byteenable[0]) begin
            clock_divide_value[gi] <=
              writedata[tcs_pkg::DIVIDE_HI_BIT:0];
          end
        end
      end

      // Compare value
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          compare_value_register[gi] <= 24'h00_0000;
        end else if (ce && wr_cmp) begin
          compare_value_register[gi] <=
            (compare_value_register[gi] & ~wmask[23:0]) |
            (writedata[23:0] & wmask[23:0]);
        end
      end

      // Prescaler: holds its phase while suspended
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          clock_divide_value_reg <= 8'h00;
        end else if (ce) begin
          if (clear_go || tick) begin
            clock_divide_value_reg <= 8'h00;
          end else if (count_enable[gi]) begin
            clock_divide_value_reg <= clock_divide_value_reg + 8'h01;
          end
        end
      end

      // Up-timer: no tick while disabled, so the count is kept
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          count_reg[gi] <= 24'h00_0000;
        end else if (ce) begin
          if (clear_go) begin
            count_reg[gi] <= 24'h00_0000;
          end else if (match && mode[gi] != tcs_pkg::MODE_AUTO) begin
            count_reg[gi] <= 24'h00_0000;
          end else if (tick) begin
            count_reg[gi] <= count_inc;
          end
        end
      end

      // Square wave: one half period per match
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          toggle_out[gi] <= 1'b0;
        end else if (ce && match && mode[gi] == tcs_pkg::MODE_TOGGLE) begin
          toggle_out[gi] <= !toggle_out[gi];
        end
      end

      // Data register follows the count only while enabled
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          live_count_register[gi] <= 24'h00_0000;
        end else if (ce && data_snapshot_enable[gi]) begin
          live_count_register[gi] <= count_reg[gi];
        end
      end
    end
  endgenerate

  // ******************************************************
  // Interrupt status and mask
  // ******************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
    end else if (ce) begin
      // A new match wins over a write-one-to-clear
      if (wr_go && address == tcs_pkg::IRQ_STATUS_OFS && byteenable[0]) begin
        irq_status_reg <= match_event |
          (irq_status_reg & ~writedata[tcs_pkg::CH_NUM-1:0]);
      end else begin
        irq_status_reg <= irq_status_reg | match_event;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= '0;
    end else if (ce && wr_go && address == tcs_pkg::IRQ_MASK_OFS &&
                 byteenable[0]) begin
      irq_mask_reg <= writedata[tcs_pkg::CH_NUM-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ******************************************************
  // Read path and wait states
  // ******************************************************
  always_comb begin
    rd_next = 32'h0000_0000;
    for (int i = 0; i < tcs_pkg::CH_NUM; i++) begin
      if (ch_hit(address, i, tcs_pkg::CTRL_IDX)) begin
        rd_next[tcs_pkg::COUNT_ENABLE_BIT] = count_enable[i];
        rd_next[tcs_pkg::IRQ_ENABLE_BIT]   = match_irq_enable[i];
        rd_next[tcs_pkg::MODE_HI_BIT:tcs_pkg::MODE_LO_BIT] = mode[i];
        rd_next[tcs_pkg::ACTIVE_BIT]       = count_enable[i];
        rd_next[tcs_pkg::EVENT_SEL_BIT]    = event_count_select[i];
        rd_next[tcs_pkg::SNAPSHOT_BIT]     = data_snapshot_enable[i];
        rd_next[tcs_pkg::DIVIDE_HI_BIT:0]  = clock_divide_value[i];
      end
      if (ch_hit(address, i, tcs_pkg::CMP_IDX)) begin
        rd_next[23:0] = compare_value_register[i];
      end
      if (ch_hit(address, i, tcs_pkg::DATA_IDX)) begin
        rd_next[23:0] = live_count_register[i];
      end
    end
    if (address == tcs_pkg::IRQ_STATUS_OFS) begin
      rd_next[tcs_pkg::CH_NUM-1:0] = irq_status_reg;
    end
    if (address == tcs_pkg::IRQ_MASK_OFS) begin
      rd_next[tcs_pkg::CH_NUM-1:0] = irq_mask_reg;
    end
  end

  // One wait state per access; a release cycle follows each answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (ce) begin
      if ((read || write) && waitrequest) begin
        waitrequest <= 1'b0;
        readdata    <= rd_next;
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

endmodule : tcs_timer_control_status
`default_nettype wire

// ===== testbench/tcs_timer_control_status_properties.sv
`default_nettype none
module tcs_timer_control_status_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  // Register bus
  input wire logic [9:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Channel outputs
  input wire logic [3:0]  toggle_out,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rack;
  logic ctl;
  assign rack = read && !waitrequest;
  assign ctl  = !address[9] && address[7:6] == 2'h0 && address[4:0] == 5'h00;
  // ****************************************
  // Properties
  // ****************************************
  one_wait_a: assert property (
    (read || write) && waitrequest && ce |=> !waitrequest)
    else $error("request not answered after one wait state");
  wait_pulse_a: assert property (
    !waitrequest && ce |=> waitrequest)
    else $error("answer held longer than one cycle");
  clear_self_a: assert property (rack && ctl |-> !readdata[26])
    else $error("clear bit reads back as one");
  active_flag_a: assert property (
    rack && ctl |-> readdata[25] == readdata[30])
    else $error("active flag differs from enable");
  reserved_zero_a: assert property (rack && ctl |->
    !readdata[31] && readdata[23:17] == 7'h00 && readdata[15:8] == 8'h00)
    else $error("reserved control bits not zero");
  count_width_a: assert property (
    rack && !address[9] && address[2] |-> readdata[31:24] == 8'h00)
    else $error("count or compare wider than 24 bits");
  mask_off_a: assert property (
    write && !waitrequest && address == tcs_pkg::IRQ_MASK_OFS && ce
    && byteenable[0] && writedata[3:0] == 4'h0 ##1 ce |=> !irq)
    else $error("irq high with all sources masked");
  reset_idle_a: assert property ($rose(rst_n) |->
    waitrequest && !irq && toggle_out == 4'h0)
    else $error("outputs not idle after reset");
  freeze_a: assert property (
    !ce |=> $stable(toggle_out) && $stable(irq) && $stable(waitrequest))
    else $error("state moved while frozen");
  cover property ($rose(irq));
  cover property (toggle_out != $past(toggle_out));
  cover property (rack && ctl);
endmodule : tcs_timer_control_status_checker

bind tcs_timer_control_status tcs_timer_control_status_checker u_chk (
  .clk(clk), .rst_n(rst_n), .ce(ce), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest),
  .toggle_out(toggle_out), .irq(irq));
`default_nettype wire

// ===== testbench/tcs_timer_control_status_tb.sv
`default_nettype none
module tcs_timer_control_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} tcs_exp_t;
  localparam logic [9:0] sts_a = tcs_pkg::IRQ_STATUS_OFS;
  localparam logic [9:0] msk_a = tcs_pkg::IRQ_MASK_OFS;
  logic        clk         = 1'b0;
  logic        rst_n       = 1'b0;
  logic        ce          = 1'b1;
  logic [9:0]  address     = 10'h000;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0;
  logic [3:0]  byteenable  = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  toggle_out;
  logic        irq;
  int          num_errors  = 0;
  int          n_tests     = 0;
  integer      seed        = 32'hEEDE51A0;
  tcs_exp_t    expq[$];
  tcs_exp_t    e;
  logic [31:0] rnd[4];
  logic        t;

  tcs_timer_control_status dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .toggle_out(toggle_out), .irq(irq));

  always #20 clk = ~clk;

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %s expected %h got %h", nm, ex, got);
    end
  endtask : chk

  // Oldest note is matched against each read answer
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      chk("readdata", e.v, readdata & e.m);
    end
  end

  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    @(posedge clk);
    for (k = 0; waitrequest !== 1'b0 && k < 50; k++) @(posedge clk);
    if (k == 50) chk("waitrequest", 32'h0, 32'h1);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [9:0] a, input logic [31:0] v,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    expq.push_back('{v, m});
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  function automatic logic [9:0] ofs(input int c, input logic [9:0] r);
    return (c > 1 ? tcs_pkg::TIMER_PAIR_B_BASE : tcs_pkg::TIMER_PAIR_A_BASE)
      + (c % 2 == 1 ? tcs_pkg::CH_SECOND_OFS : tcs_pkg::CH_FIRST_OFS) + r;
  endfunction : ofs

  // Enabled for exactly eight edges, given the one wait state per write
  task automatic run(input int c, input logic [31:0] w);
    wr(ofs(c, 10'h0), w | 32'h4000_0000);
    repeat (5) @(posedge clk);
    wr(ofs(c, 10'h0), w);
  endtask : run

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rd(ofs(c, 10'h0), tcs_pkg::CTRL_RESET);
      rnd[c] = $random(seed);
      wr(ofs(c, 10'h4), rnd[c]);
    end
    for (int c = 0; c < 4; c++) begin
      rd(ofs(c, 10'h4), rnd[c] & 32'h00FF_FFFF);
    end
    wr(10'h008, 32'hFFFF_FFFF);
    rd(10'h008, 32'h0);
    rd(msk_a, 32'h0);
    $display("test map done");
    wr(ofs(0, 10'h0), 32'hFFFF_FFFF);
    rd(ofs(0, 10'h0), 32'h3901_00FF);
    byteenable <= 4'h1;
    wr(ofs(1, 10'h0), 32'hFFFF_FF33);
    byteenable <= 4'hF;
    rd(ofs(1, 10'h0), 32'h0000_0033);
    $display("test fields done");
    // A random compare could match inside the counted window
    wr(ofs(2, 10'h4), 32'h0);
    for (int d = 0; d < 8; d = d * 2 + 1) begin
      wr(ofs(2, 10'h0), 32'h0C01_0000 | d);
      run(2, 32'h0801_0000 | d);
      rd(ofs(2, 10'hC), 32'(8 / (d + 1)));
    end
    run(2, 32'h0801_0007);
    rd(ofs(2, 10'hC), 32'h2);
    rd(ofs(2, 10'h0), 32'h0801_0007);
    $display("test divide done");
    wr(ofs(1, 10'h4), 32'h3);
    wr(msk_a, 32'hF);
    run(1, 32'h3801_0000);
    rd(ofs(1, 10'hC), 32'h8);
    rd(sts_a, 32'h2, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(sts_a, 32'h2);
    rd(sts_a, 32'h0, 32'h2);
    $display("test auto done");
    wr(ofs(0, 10'h4), 32'h3);
    wr(ofs(0, 10'h0), 32'h6001_0000);
    repeat (10) @(posedge clk);
    rd(ofs(0, 10'h0), 32'h2001_0000);
    rd(ofs(0, 10'hC), 32'h0);
    rd(sts_a, 32'h1, 32'h1);
    wr(sts_a, 32'h1);
    repeat (10) @(posedge clk);
    rd(sts_a, 32'h0, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test one shot done");
    wr(ofs(0, 10'h0), 32'h6801_0000);
    repeat (4) @(posedge clk);
    wr(sts_a, 32'h1);
    repeat (6) @(posedge clk);
    rd(sts_a, 32'h1, 32'h1);
    rd(ofs(0, 10'h0), 32'h4200_0000, 32'h4200_0000);
    chk("irq", 32'h1, {31'h0, irq});
    wr(msk_a, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ofs(0, 10'h0), 32'h4801_0000);
    wr(sts_a, 32'hF);
    repeat (8) @(posedge clk);
    rd(sts_a, 32'h0, 32'h1);
    $display("test periodic done");
    wr(ofs(3, 10'h4), 32'h2);
    wr(ofs(3, 10'h0), 32'h5000_0000);
    t = toggle_out[3];
    for (int k = 0; k < 20 && toggle_out[3] === t; k++) @(posedge clk);
    t = toggle_out[3];
    @(posedge clk);
    chk("toggle", {31'h0, t}, {31'h0, toggle_out[3]});
    @(posedge clk);
    chk("toggle", {31'h0, !t}, {31'h0, toggle_out[3]});
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    $display("test toggle done");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : tcs_timer_control_status_tb
`default_nettype wire
